// >>> rtl/sticky_bit.sv
// sticky status bit, set wins over clear, masked request out
`timescale 1ns/1ps
`default_nettype none
module sticky_bit (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// set, clear and mask
	input wire logic set_in,
	input wire logic clear_in,
	input wire logic enable_in,
	// status and masked request
	output logic status_out,
	output logic request_out
);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_out <= 1'b0;
		end else if (set_in) begin
			status_out <= 1'b1;
		end else if (clear_in) begin
			status_out <= 1'b0;
		end
	end
	assign request_out = status_out & enable_in;
endmodule : sticky_bit
`default_nettype wire

// >>> rtl/sync_two_stage.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module sync_two_stage (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// level in and out
	input wire logic async_in,
	output logic sync_out
);
	import vbus_ctrl_pkg::*;
	logic meta_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_reg <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule : sync_two_stage
`default_nettype wire

// >>> rtl/usb_vbus_power_pullup_ctrl.sv
// vbus power enable, over-current and pullup enable control with axi4-lite registers
//
// Overview of operation
// - power enable high exactly when port power set
// - over-current active level chosen by polarity bit
// - active over-current sets over-current flag
// - over-current is port change, may interrupt
// - revision below two forces active-high over-current
// - dual-role side has no power or over-current
// - pullup enable follows session valid bit
`timescale 1ns/1ps
`default_nettype none
module usb_vbus_power_pullup_ctrl #(
	parameter logic [3:0] PART_REVISION = 4'h2 // arbitrary value
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// host port power switch
	output logic host_port_power_enable_out,
	input wire logic host_over_current_in,
	// other host port change events
	input wire logic port_event_in,
	// dual-role pullup gating
	output logic dual_role_pullup_enable_out,
	// interrupt
	output logic irq_out
);
	import vbus_ctrl_pkg::*;

	// ****************************************
	// declarations
	// ****************************************
	logic [7:0] awaddr_reg;
	logic aw_full_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic w_full_reg;
	logic do_write;
	logic lane0;
	logic port_power_reg;
	logic port_change_en_reg;
	logic polarity_sel_reg;
	logic session_valid_reg;
	logic oc_sync;
	logic oc_active;
	logic oc_active_prev_reg;
	logic oc_rise;
	logic oca_flag;
	logic oca_clear;
	logic pc_status;
	logic pc_clear;
	logic polarity_allowed;
	logic [31:0] rdata_next;
	logic rresp_bad;

	// ****************************************
	// axi write channel
	// ****************************************
	assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_full_reg && !s_axi_bvalid;
	assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
	assign lane0 = wstrb_reg[0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			awaddr_reg <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_full_reg <= 1'b1;
			awaddr_reg <= s_axi_awaddr;
		end else if (do_write) begin
			aw_full_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full_reg <= 1'b0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_full_reg <= 1'b1;
			wdata_reg <= s_axi_wdata;
			wstrb_reg <= s_axi_wstrb;
		end else if (do_write) begin
			w_full_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			case (awaddr_reg)
				PORT_STATUS_CONTROL_OFS, USB_IRQ_ENABLE_OFS, IRQ_STATUS_OFS, IRQ_CLEAR_OFS,
				SYSTEM_BUS_CONFIG_OFS, CHIP_IDENT_OFS, DUAL_ROLE_CTRL_STATUS_OFS: begin
					s_axi_bresp <= RESP_OKAY;
				end
				default: begin
					s_axi_bresp <= RESP_DECERR;
				end
			endcase
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ****************************************
	// control registers
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_power_reg <= PORT_POWER_RST;
		end else if (do_write && lane0 && awaddr_reg == PORT_STATUS_CONTROL_OFS) begin
			port_power_reg <= wdata_reg[PORT_POWER_POS];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_change_en_reg <= PORT_CHANGE_EN_RST;
		end else if (do_write && lane0 && awaddr_reg == USB_IRQ_ENABLE_OFS) begin
			port_change_en_reg <= wdata_reg[PORT_CHANGE_POS];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			polarity_sel_reg <= POLARITY_SEL_RST;
		end else if (do_write && lane0 && awaddr_reg == SYSTEM_BUS_CONFIG_OFS) begin
			polarity_sel_reg <= wdata_reg[POLARITY_SEL_POS];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			session_valid_reg <= SESSION_VALID_RST;
		end else if (do_write && lane0 && awaddr_reg == DUAL_ROLE_CTRL_STATUS_OFS) begin
			session_valid_reg <= wdata_reg[SESSION_VALID_POS];
		end
	end

	assign oca_clear = do_write && lane0 && awaddr_reg == PORT_STATUS_CONTROL_OFS
		&& wdata_reg[OVER_CURRENT_ACTIVE_POS];
	assign pc_clear = do_write && lane0 && awaddr_reg == IRQ_CLEAR_OFS && wdata_reg[PORT_CHANGE_POS];

	// ****************************************
	// over-current path
	// ****************************************
	sync_two_stage u_oc_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(host_over_current_in),
		.sync_out(oc_sync)
	);

	assign polarity_allowed = PART_REVISION >= POLARITY_MIN_REV;
	assign oc_active = oc_sync ^ (polarity_sel_reg & polarity_allowed);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			oc_active_prev_reg <= 1'b0;
		end else begin
			oc_active_prev_reg <= oc_active;
		end
	end
	assign oc_rise = oc_active && !oc_active_prev_reg;

	sticky_bit u_oca_flag (
		.aclk(aclk),
		.aresetn(aresetn),
		.set_in(oc_active),
		.clear_in(oca_clear),
		.enable_in(1'b0),
		.status_out(oca_flag),
		.request_out()
	);

	sticky_bit u_port_change (
		.aclk(aclk),
		.aresetn(aresetn),
		.set_in(oc_rise || port_event_in),
		.clear_in(pc_clear),
		.enable_in(port_change_en_reg),
		.status_out(pc_status),
		.request_out(irq_out)
	);

	// ****************************************
	// pin outputs
	// ****************************************
	assign host_port_power_enable_out = port_power_reg;
	assign dual_role_pullup_enable_out = session_valid_reg;

	// ****************************************
	// axi read channel
	// ****************************************
	assign s_axi_arready = !s_axi_rvalid;

	always_comb begin
		rdata_next = 32'h0000_0000;
		rresp_bad = 1'b0;
		case (s_axi_araddr)
			PORT_STATUS_CONTROL_OFS: begin
				rdata_next[PORT_POWER_POS] = port_power_reg;
				rdata_next[OVER_CURRENT_ACTIVE_POS] = oca_flag;
			end
			USB_IRQ_ENABLE_OFS: begin
				rdata_next[PORT_CHANGE_POS] = port_change_en_reg;
			end
			IRQ_STATUS_OFS: begin
				rdata_next[PORT_CHANGE_POS] = pc_status;
			end
			IRQ_CLEAR_OFS: begin
				rdata_next = 32'h0000_0000;
			end
			SYSTEM_BUS_CONFIG_OFS: begin
				rdata_next[POLARITY_SEL_POS] = polarity_sel_reg;
			end
			CHIP_IDENT_OFS: begin
				rdata_next[REVISION_LSB +: REVISION_W] = PART_REVISION;
			end
			DUAL_ROLE_CTRL_STATUS_OFS: begin
				rdata_next[SESSION_VALID_POS] = session_valid_reg;
			end
			default: begin
				rresp_bad = 1'b1;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdata_next;
			s_axi_rresp <= rresp_bad ? RESP_DECERR : RESP_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_oc_rise_enabled;
		oc_rise && port_change_en_reg;
	endsequence

	sequence s_oc_held;
		oc_active [*2];
	endsequence

	a_power_follows_bit: assert property (
		do_write && lane0 && awaddr_reg == PORT_STATUS_CONTROL_OFS
		|=> host_port_power_enable_out == $past(wdata_reg[PORT_POWER_POS]))
		else $error("power enable does not follow port power bit");
	a_polarity_select: assert property (
		polarity_allowed && polarity_sel_reg && !oc_sync |-> oc_active)
		else $error("low over-current input not active under inverted polarity");
	a_oca_sets_flag: assert property (
		s_oc_held |-> oca_flag)
		else $error("over-current flag not set while fault active");
	a_oc_irq_raise: assert property (
		s_oc_rise_enabled |=> pc_status && irq_out)
		else $error("over-current did not raise port change interrupt");
	a_old_rev_high: assert property (
		!polarity_allowed |-> oc_active == oc_sync)
		else $error("old revision over-current not active high");
	a_pullup_no_oc: assert property (
		oc_rise && !do_write |=> $stable(dual_role_pullup_enable_out))
		else $error("over-current disturbed dual-role pullup");
	a_pullup_follow: assert property (
		do_write && lane0 && awaddr_reg == DUAL_ROLE_CTRL_STATUS_OFS
		|=> dual_role_pullup_enable_out == $past(wdata_reg[SESSION_VALID_POS]))
		else $error("pullup enable does not follow session valid bit");
	a_sync_delay: assert property (
		##2 oc_sync == $past(host_over_current_in, 2))
		else $error("over-current synchroniser delay is not two cycles");
endmodule : usb_vbus_power_pullup_ctrl
`default_nettype wire

// >>> rtl/vbus_ctrl_pkg.sv
// constants for the vbus power and pullup sideband control block
package vbus_ctrl_pkg;
	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0] PORT_STATUS_CONTROL_OFS = 8'h00;
	localparam logic [7:0] USB_IRQ_ENABLE_OFS = 8'h04;
	localparam logic [7:0] IRQ_STATUS_OFS = 8'h08;
	localparam logic [7:0] IRQ_CLEAR_OFS = 8'h0C;
	localparam logic [7:0] SYSTEM_BUS_CONFIG_OFS = 8'h10;
	localparam logic [7:0] CHIP_IDENT_OFS = 8'h14;
	localparam logic [7:0] DUAL_ROLE_CTRL_STATUS_OFS = 8'h18;
	// ****************************************
	// field positions
	// ****************************************
	localparam int PORT_POWER_POS = 0;
	localparam int OVER_CURRENT_ACTIVE_POS = 1;
	localparam int PORT_CHANGE_POS = 0;
	localparam int POLARITY_SEL_POS = 0;
	localparam int SESSION_VALID_POS = 0;
	localparam int REVISION_LSB = 0;
	localparam int REVISION_W = 4;
	// ****************************************
	// reset values and limits
	// ****************************************
	localparam logic PORT_POWER_RST = 1'b0;
	localparam logic PORT_CHANGE_EN_RST = 1'b0;
	localparam logic POLARITY_SEL_RST = 1'b0;
	localparam logic SESSION_VALID_RST = 1'b0;
	localparam logic [REVISION_W-1:0] POLARITY_MIN_REV = 4'h2;
	localparam logic [REVISION_W-1:0] DEFAULT_REV = 4'h2;
	localparam int SYNC_STAGES = 2;
	// ****************************************
	// axi responses
	// ****************************************
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : vbus_ctrl_pkg

// >>> testbench/tb_top.sv
// self-checking bench for the vbus power and pullup block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import vbus_ctrl_pkg::*;
	logic aclk, aresetn, awvalid, wvalid, arvalid, fault, low_act, vbus_in, ev;
	logic awready, wready, bvalid, arready, rvalid, pwr, pu, irq, flag, pvbus, pu_act, irq_old;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, v, rv;
	logic [1:0] bresp, rresp, r;
	integer mismatches, checks_done, cyc, seed, pp;
	usb_vbus_power_pullup_ctrl #(.PART_REVISION(4'h2)) dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
		.host_port_power_enable_out(pwr), .host_over_current_in(flag), .port_event_in(ev),
		.dual_role_pullup_enable_out(pu), .irq_out(irq));
	// early revision copy on the same bus, over-current fixed active high
	usb_vbus_power_pullup_ctrl #(.PART_REVISION(4'h1)) dut_old (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(),
		.s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(1'b1),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(),
		.s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(1'b1),
		.host_port_power_enable_out(), .host_over_current_in(flag), .port_event_in(ev),
		.dual_role_pullup_enable_out(), .irq_out(irq_old));
	vbus_switch_model partner (.power_en(pwr), .fault_req(fault), .flag_active_low(low_act),
		.flag_out(flag), .port_vbus(pvbus), .pullup_en(pu), .vbus_in(vbus_in), .pullup_active(pu_act));
	// ****************************************
	// clock, watchdog and tasks
	// ****************************************
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			mismatches = mismatches + 1;
			test_done();
		end
	end
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp) begin
			mismatches = mismatches + 1;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
	endtask : wr
	task rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		v = rdata;
		r = rresp;
	endtask : rd
	task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(nm, v, exp);
		chk("read resp", 32'(r), 32'(RESP_OKAY));
	endtask : rdc
	task clr_all();
		repeat (4) @(posedge aclk);
		wr(PORT_STATUS_CONTROL_OFS, 32'(pp) | 32'h2);
		wr(IRQ_CLEAR_OFS, 32'h1);
	endtask : clr_all
	task test_done();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : test_done
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{aresetn, awvalid, wvalid, arvalid, fault, low_act, vbus_in, ev} = 8'h00;
		{awaddr, araddr, wdata} = 48'h0;
		{mismatches, checks_done, cyc, pp} = 128'h0;
		seed = 32'h4321DA39;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rdc("port status", PORT_STATUS_CONTROL_OFS, 0);
		rdc("ident", CHIP_IDENT_OFS, 32'h2);
		rdc("polarity", SYSTEM_BUS_CONFIG_OFS, 0);
		chk("pins", 32'({pwr, pu, irq}), 0);
		repeat (8) begin
			rv = $random(seed);
			pp = rv[0];
			wr(PORT_STATUS_CONTROL_OFS, 32'(rv[0]));
			chk("power enable", 32'(pwr), 32'(pp));
			wr(DUAL_ROLE_CTRL_STATUS_OFS, 32'(rv[1]));
			chk("pullup", 32'(pu), 32'(rv[1]));
			rdc("port status", PORT_STATUS_CONTROL_OFS, 32'(pp));
		end
		$display("test random pins done");
		wr(USB_IRQ_ENABLE_OFS, 32'h1);
		wr(PORT_STATUS_CONTROL_OFS, 32'h1);
		pp = 1;
		fault <= 1'b1;
		repeat (3) @(posedge aclk);
		chk("irq early", 32'(irq), 0);
		@(posedge aclk);
		chk("irq", 32'(irq), 1);
		rdc("flag set", PORT_STATUS_CONTROL_OFS, 32'h3);
		rdc("irq status", IRQ_STATUS_OFS, 1);
		pp = 0;
		wr(PORT_STATUS_CONTROL_OFS, 32'h2);
		chk("power off", 32'({pwr, pvbus}), 0);
		rdc("flag held", PORT_STATUS_CONTROL_OFS, 32'h2);
		fault <= 1'b0;
		clr_all();
		rdc("flag clear", PORT_STATUS_CONTROL_OFS, 0);
		chk("irq off", 32'(irq), 0);
		$display("test high fault done");
		low_act <= 1'b1;
		wr(SYSTEM_BUS_CONFIG_OFS, 32'h1);
		@(posedge aclk);
		chk("old rev irq", 32'(irq_old), 1);
		chk("inverted idle irq", 32'(irq), 0);
		clr_all();
		rdc("quiet low", PORT_STATUS_CONTROL_OFS, 0);
		fault <= 1'b1;
		repeat (4) @(posedge aclk);
		rdc("low fault", PORT_STATUS_CONTROL_OFS, 32'h2);
		chk("irq low", 32'(irq), 1);
		wr(USB_IRQ_ENABLE_OFS, 0);
		chk("irq masked", 32'(irq), 0);
		rdc("status kept", IRQ_STATUS_OFS, 1);
		fault <= 1'b0;
		clr_all();
		wr(USB_IRQ_ENABLE_OFS, 32'h1);
		ev <= 1'b1;
		@(posedge aclk);
		ev <= 1'b0;
		repeat (3) @(posedge aclk);
		chk("event irq", 32'(irq), 1);
		clr_all();
		$display("test low fault done");
		wr(8'h1C, 32'hFFFFFFFF);
		chk("bad write", 32'(r), 32'(RESP_DECERR));
		rd(8'h1C);
		chk("bad read", {v[29:0], r}, 32'(RESP_DECERR));
		wr(CHIP_IDENT_OFS, 0);
		rdc("ident kept", CHIP_IDENT_OFS, 32'h2);
		rdc("clear reads", IRQ_CLEAR_OFS, 0);
		vbus_in <= 1'b1;
		@(posedge aclk);
		if (pvbus === 1'b0 && vbus_in === 1'b1) wr(DUAL_ROLE_CTRL_STATUS_OFS, 32'h1);
		chk("pullup on", 32'({pu, pu_act}), 32'h3);
		vbus_in <= 1'b0;
		@(posedge aclk);
		chk("pullup gated", 32'({pu, pu_act}), 32'h2);
		wr(DUAL_ROLE_CTRL_STATUS_OFS, 0);
		chk("pullup off", 32'(pu), 0);
		$display("test regs and pullup done");
		test_done();
	end
endmodule : tb_top
`default_nettype wire

// >>> testbench/vbus_switch_model.sv
// behavioural power switch and pullup gate beside the block
`timescale 1ns/1ps
`default_nettype none
module vbus_switch_model (
	// switch enable and fault flag
	input wire logic power_en,
	input wire logic fault_req,
	input wire logic flag_active_low,
	output logic flag_out,
	output logic port_vbus,
	// pullup gate
	input wire logic pullup_en,
	input wire logic vbus_in,
	output logic pullup_active
);
	assign flag_out = fault_req ^ flag_active_low;
	assign port_vbus = power_en & ~fault_req;
	assign pullup_active = pullup_en & vbus_in;
endmodule : vbus_switch_model
`default_nettype wire
